// *** bwfp_params.svh ***
// Constants for the byte-wide FIFO port: timing counts, depths, reset values.
// Assumes a 200 MHz system clock; included by the package, the port and the testbench.
// Notes on behaviour
// - Sync mode moves one direction per clock.
// - Sync bytes move on output clock rise.
// - Sync mode drives a 60 MHz clock.
// - Read flag low when a byte waits.
// - First byte on bus once enable low.
// - Next byte follows clock with strobe low.
// - Read flag high once buffer empties.
// - Writes may follow on every clock.
// - Byte taken when space flag, strobe low.
// - Async moves bytes on strobe falling edges.
// - Async has no clock, ignores enable.
// - Read flag stays high 49 ns after read.
// - Space flag stays high 49 ns after write.
// - One kilobyte buffers each way set flags.
`ifndef BWFP_PARAMS_SVH
`define BWFP_PARAMS_SVH

`define BWFP_DATA_W         8
`define BWFP_BUF_DEPTH      1024
`define BWFP_CLK_NS         5
`define BWFP_SYS_MHZ        200
`define BWFP_LINK_MHZ       60
// Phase step counts half periods of the link clock
`define BWFP_PHASE_STEP     (2 * `BWFP_LINK_MHZ)
`define BWFP_FLAG_HOLD_NS   49
`define BWFP_FLAG_HOLD_CYC  ((`BWFP_FLAG_HOLD_NS + `BWFP_CLK_NS - 1) / `BWFP_CLK_NS)
`define BWFP_STROBE_MIN_NS  30
`define BWFP_STROBE_MIN_CYC ((`BWFP_STROBE_MIN_NS + `BWFP_CLK_NS - 1) / `BWFP_CLK_NS)
`define BWFP_FLAG_RST       1'b1
`define BWFP_PIN_RST        1'b1
`define BWFP_CLK_OUT_RST    1'b0

`endif

// *** bwfp_pkg.sv ***
// Types shared by the byte-wide FIFO port files.
// Assumes nothing beyond the params header.
`include "bwfp_params.svh"
package bwfp_pkg;
	typedef logic [`BWFP_DATA_W-1:0] bwfp_byte_t;
	typedef enum logic [1:0] {
		MODE_ASYNC = 2'b01,
		MODE_SYNC  = 2'b10
	} bwfp_mode_t;
	typedef enum logic [3:0] {
		AS_IDLE    = 4'b0001,
		AS_READ    = 4'b0010,
		AS_WRITE   = 4'b0100,
		AS_RECOVER = 4'b1000
	} bwfp_astate_t;
endpackage

// *** bwfp_fifo.sv ***
// Byte buffer with registered flags and fill level.
// Assumes one clock; pushes and pops are qualified by ce.
`timescale 1ns/1ps
module bwfp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 1024,
	localparam int AW   = $clog2(DEPTH)
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready,
	output logic [AW:0]           level
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      next_level;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	// Level and flags move together so full and empty never lag
	assign next_level = level + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data   = mem[rd_ptr];

	////////////////////////////////////////////////////////////////////////
	// Storage, no reset needed on the array
	always_ff @(posedge clk_sys) begin
		if (ce && push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and flags
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			level     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else if (ce) begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			level     <= next_level;
			in_ready  <= next_level != (AW+1)'(DEPTH);
			out_valid <= next_level != '0;
		end
	end
endmodule

// *** bwfp_port.sv ***
// Byte-wide FIFO port: pin side in sync or async mode, two byte buffers.
// Assumes pins are asynchronous to clk_sys; the USB side is on clk_sys.
`timescale 1ns/1ps
`include "bwfp_params.svh"
module bwfp_port #(
	parameter int DEPTH = `BWFP_BUF_DEPTH,
	localparam int AW   = $clog2(DEPTH)
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic             ce,
	input  wire logic             sync_mode_sel,
	input  wire logic             rd_n,
	input  wire logic             wr_n,
	input  wire logic             oe_n,
	input  wire bwfp_pkg::bwfp_byte_t data_in,
	output bwfp_pkg::bwfp_byte_t  data_out,
	output logic                  data_oe_n,
	output logic                  rx_data_available_n,
	output logic                  tx_space_available_n,
	output logic                  fifo_clock_out,
	input  wire logic             usb_rx_valid,
	input  wire bwfp_pkg::bwfp_byte_t usb_rx_data,
	output logic                  usb_rx_ready,
	output logic                  usb_tx_valid,
	output bwfp_pkg::bwfp_byte_t  usb_tx_data,
	input  wire logic             usb_tx_ready
);
	import bwfp_pkg::*;

	localparam int HOLD_CYC       = `BWFP_FLAG_HOLD_CYC;
	localparam logic [7:0] P_STEP = 8'(`BWFP_PHASE_STEP);
	localparam logic [8:0] P_MOD  = 9'(`BWFP_SYS_MHZ);
	localparam logic [3:0] HOLD   = 4'(HOLD_CYC);

	logic [1:0]   rd_sy;
	logic [1:0]   wr_sy;
	logic [1:0]   oe_sy;
	bwfp_byte_t   din_m;
	bwfp_byte_t   din_s;
	logic         rd_q;
	logic         wr_q;
	bwfp_mode_t   mode;
	bwfp_astate_t st;
	bwfp_astate_t next_st;
	logic [3:0]   cnt;
	logic [7:0]   phase;
	logic         rx_valid;
	bwfp_byte_t   rx_head;
	logic [AW:0]  rx_level;
	logic         tx_ready;
	logic [AW:0]  tx_level;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_sy <= {2{`BWFP_PIN_RST}};
			wr_sy <= {2{`BWFP_PIN_RST}};
			oe_sy <= {2{`BWFP_PIN_RST}};
			din_m <= '0;
			din_s <= '0;
			rd_q  <= `BWFP_PIN_RST;
			wr_q  <= `BWFP_PIN_RST;
		end else if (ce) begin
			rd_sy <= {rd_sy[0], rd_n};
			wr_sy <= {wr_sy[0], wr_n};
			oe_sy <= {oe_sy[0], oe_n};
			din_m <= data_in;
			din_s <= din_m;
			rd_q  <= rd_sy[1];
			wr_q  <= wr_sy[1];
		end
	end

	// Strobe levels and edges, all on synchronised copies
	wire rd_s    = rd_sy[1];
	wire wr_s    = wr_sy[1];
	wire oe_s    = oe_sy[1];
	wire rd_fall = rd_q & ~rd_s;
	wire rd_rise = ~rd_q & rd_s;
	wire wr_fall = wr_q & ~wr_s;
	wire wr_rise = ~wr_q & wr_s;
	wire sync_m  = (mode == MODE_SYNC);

	////////////////////////////////////////////////////////////////////////
	// Link clock from a phase accumulator; 200/60 is not whole, so edges
	// jitter by one system cycle while the mean rate stays exact
	wire [8:0] phase_sum  = {1'b0, phase} + {1'b0, P_STEP};
	wire       wrap       = phase_sum >= P_MOD;
	wire [7:0] next_phase = wrap ? 8'(phase_sum - P_MOD) : phase_sum[7:0];
	wire       link_rise  = sync_m & wrap & ~fifo_clock_out;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			phase          <= '0;
			fifo_clock_out <= `BWFP_CLK_OUT_RST;
			mode           <= MODE_ASYNC;
		end else if (ce) begin
			mode  <= sync_mode_sel ? MODE_SYNC : MODE_ASYNC;
			phase <= next_phase;
			if (!sync_m) begin
				fifo_clock_out <= 1'b0;
			end else if (wrap) begin
				fifo_clock_out <= ~fifo_clock_out;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transfer qualifiers; a raised read flag blocks pops of stale bytes
	wire s_pop  = link_rise & ~rx_data_available_n & ~oe_s & ~rd_s
		& rx_valid;
	// Write needs bus not turned toward the host
	wire s_push = link_rise & ~tx_space_available_n & ~wr_s & oe_s
		& tx_ready;
	wire a_idle = ~sync_m & (st == AS_IDLE);
	wire a_pop  = a_idle & rd_fall & ~rx_data_available_n & rx_valid;
	wire a_push = a_idle & wr_fall & ~a_pop & ~tx_space_available_n
		& tx_ready;
	wire pop    = s_pop | a_pop;
	wire push   = s_push | a_push;

	// Flag look-ahead so the last byte or slot is not offered twice
	wire rx_last  = rx_level == (AW+1)'(1);
	wire tx_last  = tx_level == (AW+1)'(DEPTH - 1);
	wire nx_rxf_s = ~rx_valid | (pop & rx_last);
	wire nx_txe_s = ~tx_ready | (push & tx_last);
	wire nx_rxf_a = (next_st != AS_IDLE) | ~rx_valid;
	wire nx_txe_a = (next_st != AS_IDLE) | ~tx_ready;

	////////////////////////////////////////////////////////////////////////
	// Async strobe sequencer
	always_comb begin
		next_st = st;
		case (st)
			AS_IDLE: begin
				if (a_pop) begin
					next_st = AS_READ;
				end else if (a_push) begin
					next_st = AS_WRITE;
				end
			end
			AS_READ: begin
				if (rd_rise) begin
					next_st = AS_RECOVER;
				end
			end
			AS_WRITE: begin
				if (wr_rise) begin
					next_st = AS_RECOVER;
				end
			end
			AS_RECOVER: begin
				if (cnt == 4'd1) begin
					next_st = AS_IDLE;
				end
			end
			default: begin
				next_st = AS_IDLE;
			end
		endcase
		if (sync_m) begin
			next_st = AS_IDLE;
		end
	end

	// State, recovery count, flags and read data
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st                   <= AS_IDLE;
			cnt                  <= '0;
			rx_data_available_n  <= `BWFP_FLAG_RST;
			tx_space_available_n <= `BWFP_FLAG_RST;
			data_out             <= '0;
			data_oe_n            <= 1'b1;
		end else if (ce) begin
			st <= next_st;
			if (next_st == AS_RECOVER && st != AS_RECOVER) begin
				cnt <= HOLD;
			end else if (st == AS_RECOVER) begin
				cnt <= cnt - 4'd1;
			end
			if (!sync_m) begin
				rx_data_available_n  <= nx_rxf_a;
				tx_space_available_n <= nx_txe_a;
			end else if (link_rise) begin
				rx_data_available_n  <= nx_rxf_s;
				tx_space_available_n <= nx_txe_s;
			end
			// Sync shows the head byte before any strobe acknowledges it
			if (sync_m || a_pop) begin
				data_out <= rx_head;
			end
			// Enable pin ignored in async, the read state owns the bus
			data_oe_n <= sync_m ? oe_s : (next_st != AS_READ);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive buffer: USB fills, pin side drains
	bwfp_fifo #(
		.WIDTH (`BWFP_DATA_W),
		.DEPTH (DEPTH)
	) u_rx_buf (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.ce        (ce),
		.in_valid  (usb_rx_valid),
		.in_data   (usb_rx_data),
		.in_ready  (usb_rx_ready),
		.out_valid (rx_valid),
		.out_data  (rx_head),
		.out_ready (pop),
		.level     (rx_level)
	);

	// Transmit buffer: pin side fills, USB drains
	bwfp_fifo #(
		.WIDTH (`BWFP_DATA_W),
		.DEPTH (DEPTH)
	) u_tx_buf (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.ce        (ce),
		.in_valid  (push),
		.in_data   (din_s),
		.in_ready  (tx_ready),
		.out_valid (usb_tx_valid),
		.out_data  (usb_tx_data),
		.out_ready (usb_tx_ready),
		.level     (tx_level)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks; frozen cycles are excluded
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst || !ce);

	sequence s_rd_done;
		(st == AS_READ) && rd_rise;
	endsequence
	sequence s_wr_done;
		(st == AS_WRITE) && wr_rise;
	endsequence

	property p_one_dir;
		!(s_pop && s_push);
	endproperty
	a_one_dir: assert property (p_one_dir) else $error("sync read and write together");

	property p_on_rise;
		sync_m && (pop || push) |-> link_rise;
	endproperty
	a_on_rise: assert property (p_on_rise) else $error("sync transfer off clock rise");

	property p_clk_runs;
		sync_m && $past(sync_m) |-> ##[1:4] $changed(fifo_clock_out);
	endproperty
	a_clk_runs: assert property (p_clk_runs) else $error("link clock stalled");

	property p_rxf_low;
		link_rise && rx_valid && !pop |=> !rx_data_available_n;
	endproperty
	a_rxf_low: assert property (p_rxf_low) else $error("read flag not low");

	property p_rxf_high;
		link_rise && !rx_valid |=> rx_data_available_n;
	endproperty
	a_rxf_high: assert property (p_rxf_high) else $error("read flag not high");

	property p_push_cond;
		sync_m && push |-> !tx_space_available_n && !wr_s;
	endproperty
	a_push_cond: assert property (p_push_cond) else $error("write taken without flags");

	property p_no_clk_async;
		!sync_m && $past(!sync_m) |-> !fifo_clock_out;
	endproperty
	a_no_clk_async: assert property (p_no_clk_async) else $error("clock in async");

	property p_rd_hold;
		s_rd_done |=> rx_data_available_n [*8] ##1 (st == AS_RECOVER);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read flag hold short");

	property p_wr_hold;
		s_wr_done |=> tx_space_available_n [*8] ##1 (st == AS_RECOVER);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("space flag hold short");

	property p_drive;
		sync_m && $past(sync_m) && !data_oe_n |-> $past(!oe_s);
	endproperty
	a_drive: assert property (p_drive) else $error("bus driven without enable");

	property p_async_take;
		a_push |=> $changed(tx_level) || $past(usb_tx_valid && usb_tx_ready);
	endproperty
	a_async_take: assert property (p_async_take) else $error("async write lost");
endmodule

// *** bwfp_host.sv ***
// Partner model: external controller on the FIFO pins.
// Assumes clk_sys from the bench; pins move 1 ns after a rising edge.
`timescale 1ns/1ps
module bwfp_host (
	input  wire logic                 clk_sys,
	input  wire bwfp_pkg::bwfp_byte_t data_out,
	input  wire logic                 data_oe_n,
	input  wire logic                 fifo_clock_out,
	output logic                      rd_n,
	output logic                      wr_n,
	output logic                      oe_n,
	output bwfp_pkg::bwfp_byte_t      data_in
);
	import bwfp_pkg::*;
	logic       drv_en;
	bwfp_byte_t drv_val;
	bwfp_byte_t last;
	////////////////////////////////////////
	// Bus level; an idle bus toggles so a stale byte never looks valid
	assign data_in = !data_oe_n ? data_out : (drv_en && oe_n) ? drv_val : ~last;
	// An unknown bus at power-up would keep the idle pattern unknown forever
	always @(posedge clk_sys) begin
		if (!$isunknown(data_in)) begin
			last <= data_in;
		end
	end
	initial begin
		rd_n = 1'b1;
		wr_n = 1'b1;
		oe_n = 1'b1;
		drv_en = 1'b0;
		drv_val = 8'h00;
		last = 8'h00;
	end
	////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	// Async strobe held 8 cycles (40 ns); bus sampled late in the pulse
	task automatic strobe(input logic is_rd, output bwfp_byte_t got, output logic drv);
		if (is_rd) rd_n = 1'b0;
		else wr_n = 1'b0;
		step(6);
		got = data_out;
		drv = data_oe_n;
		step(2);
		rd_n = 1'b1;
		wr_n = 1'b1;
	endtask
	// Bounded wait for a rise of the link clock
	task automatic wait_rise(output logic ok);
		logic prev;
		prev = fifo_clock_out;
		ok = 1'b0;
		for (int i = 0; i < 20 && !ok; i++) begin
			step(1);
			ok = fifo_clock_out && !prev;
			prev = fifo_clock_out;
		end
	endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the byte-wide FIFO port.
// Assumes bwfp_port with an 8 byte buffer and the bwfp_host partner.
`timescale 1ns/1ps
`include "bwfp_params.svh"
module testbench;
	import bwfp_pkg::*;
	localparam int DEPTH = 8;
	logic       clk_sys, srst, ce, sync_mode_sel, rd_n, wr_n, oe_n, data_oe_n;
	logic       rx_data_available_n, tx_space_available_n, fifo_clock_out;
	logic       usb_rx_valid, usb_rx_ready, usb_tx_valid, usb_tx_ready;
	bwfp_byte_t data_in, data_out, usb_rx_data, usb_tx_data, got, b;
	logic       drv, ok;
	int         num_errors, checks;
	bwfp_byte_t q[$];

	bwfp_port #(.DEPTH(DEPTH)) u_bwfp_port (.clk_sys(clk_sys), .srst(srst), .ce(ce),
		.sync_mode_sel(sync_mode_sel), .rd_n(rd_n), .wr_n(wr_n), .oe_n(oe_n),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
		.rx_data_available_n(rx_data_available_n), .tx_space_available_n(tx_space_available_n),
		.fifo_clock_out(fifo_clock_out), .usb_rx_valid(usb_rx_valid), .usb_rx_data(usb_rx_data),
		.usb_rx_ready(usb_rx_ready), .usb_tx_valid(usb_tx_valid), .usb_tx_data(usb_tx_data),
		.usb_tx_ready(usb_tx_ready));
	bwfp_host u_bwfp_host (.clk_sys(clk_sys), .data_out(data_out), .data_oe_n(data_oe_n),
		.fifo_clock_out(fifo_clock_out), .rd_n(rd_n), .wr_n(wr_n), .oe_n(oe_n),
		.data_in(data_in));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	task automatic cmp_byte(input bwfp_byte_t g, input bwfp_byte_t e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmp_bit(input logic g, input logic e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic complete_run;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic timeout;
		cmp_bit(1'b0, 1'b1);
		complete_run();
	endtask
	// Bounded wait for a flag to go low
	task automatic wait_low(input logic is_rd);
		for (int i = 0; i < 40; i++) begin
			if (!(is_rd ? rx_data_available_n : tx_space_available_n)) return;
			step(1);
		end
		timeout();
	endtask
	// Recovery time: flag must stay high at least the hold count
	task automatic check_hold(input logic is_rd);
		int n;
		n = 0;
		while (n < 40 && (is_rd ? rx_data_available_n : tx_space_available_n)) begin
			step(1);
			n++;
		end
		cmp_bit(n >= `BWFP_FLAG_HOLD_CYC && n < 40, 1'b1);
	endtask
	task automatic usb_push(input bwfp_byte_t v);
		usb_rx_valid = 1'b1;
		usb_rx_data = v;
		for (int i = 0; i < 40 && !usb_rx_ready; i++) step(1);
		if (!usb_rx_ready) timeout();
		step(1);
		usb_rx_valid = 1'b0;
		step(1);
	endtask
	task automatic usb_pop(output bwfp_byte_t v);
		for (int i = 0; i < 40 && !usb_tx_valid; i++) step(1);
		if (!usb_tx_valid) timeout();
		v = usb_tx_data;
		usb_tx_ready = 1'b1;
		step(1);
		usb_tx_ready = 1'b0;
		step(1);
	endtask
	////////////////////////////////////////
	task automatic t_async_write;
		u_bwfp_host.drv_val = 8'hA5;
		u_bwfp_host.drv_en = 1'b1;
		wait_low(1'b0);
		step(2);
		u_bwfp_host.strobe(1'b0, got, drv);
		check_hold(1'b0);
		u_bwfp_host.drv_en = 1'b0;
		usb_pop(got);
		cmp_byte(got, 8'hA5);
		cmp_bit(fifo_clock_out, 1'b0);
	endtask
	task automatic t_async_read;
		usb_push(8'h3C);
		usb_push(8'hC3);
		wait_low(1'b1);
		u_bwfp_host.strobe(1'b1, got, drv);
		cmp_byte(got, 8'h3C);
		cmp_bit(drv, 1'b0);
		check_hold(1'b1);
		u_bwfp_host.strobe(1'b1, got, drv);
		cmp_byte(got, 8'hC3);
		step(20);
		cmp_bit(rx_data_available_n, 1'b1);
		cmp_bit(fifo_clock_out, 1'b0);
	endtask
	// Fractional divider: 3 link periods per 10 system cycles
	task automatic t_sync_clock;
		int   n;
		logic prev;
		sync_mode_sel = 1'b1;
		step(4);
		n = 0;
		for (int i = 0; i < 300; i++) begin
			prev = fifo_clock_out;
			step(1);
			if (fifo_clock_out && !prev) n++;
		end
		cmp_bit(n >= 89 && n <= 91, 1'b1);
	endtask
	// Burst read with one wait, write strobe also low: read must win
	task automatic t_sync_read;
		for (int i = 0; i < 4; i++) usb_push(bwfp_byte_t'(8'h51 + i));
		wait_low(1'b1);
		u_bwfp_host.drv_val = 8'hEE;
		u_bwfp_host.drv_en = 1'b1;
		u_bwfp_host.oe_n = 1'b0;
		u_bwfp_host.wr_n = 1'b0;
		step(6);
		cmp_byte(data_out, 8'h51);
		cmp_bit(data_oe_n, 1'b0);
		u_bwfp_host.rd_n = 1'b0;
		q = {};
		for (int i = 0; i < 80 && !rx_data_available_n; i++) begin
			if (q.size() == 0 || q[$] !== data_out) q.push_back(data_out);
			if (i == 6) u_bwfp_host.rd_n = 1'b1;
			if (i == 20) u_bwfp_host.rd_n = 1'b0;
			step(1);
		end
		if (!rx_data_available_n) timeout();
		for (int i = 0; i < 4; i++)
			cmp_byte(i < q.size() ? q[i] : 8'h00, bwfp_byte_t'(8'h51 + i));
		u_bwfp_host.rd_n = 1'b1;
		u_bwfp_host.wr_n = 1'b1;
		u_bwfp_host.oe_n = 1'b1;
		u_bwfp_host.drv_en = 1'b0;
		step(6);
		cmp_bit(data_oe_n, 1'b1);
		cmp_bit(usb_tx_valid, 1'b0);
	endtask
	// Fill the transmit buffer one byte per link rise until it refuses
	task automatic t_sync_write;
		u_bwfp_host.drv_val = 8'h10;
		u_bwfp_host.drv_en = 1'b1;
		wait_low(1'b0);
		u_bwfp_host.wait_rise(ok);
		if (!ok) timeout();
		u_bwfp_host.wr_n = 1'b0;
		for (int i = 0; i < 14; i++) begin
			u_bwfp_host.wait_rise(ok);
			if (!ok) timeout();
			u_bwfp_host.drv_val++;
		end
		u_bwfp_host.wr_n = 1'b1;
		u_bwfp_host.drv_en = 1'b0;
		cmp_bit(tx_space_available_n, 1'b1);
		usb_pop(got);
		cmp_byte(got, 8'h10);
		for (int i = 1; i < DEPTH; i++) begin
			usb_pop(b);
			cmp_byte(b, bwfp_byte_t'(got + i));
		end
		step(10);
		cmp_bit(usb_tx_valid, 1'b0);
	endtask
	////////////////////////////////////////
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		sync_mode_sel = 1'b0;
		usb_rx_valid = 1'b0;
		usb_rx_data = 8'h00;
		usb_tx_ready = 1'b0;
		num_errors = 0;
		checks = 0;
		step(16);
		cmp_bit(rx_data_available_n, 1'b1);
		cmp_bit(tx_space_available_n, 1'b1);
		cmp_bit(data_oe_n, 1'b1);
		cmp_bit(fifo_clock_out, 1'b0);
		srst = 1'b0;
		step(2);
		t_async_write();
		t_async_read();
		t_sync_clock();
		t_sync_read();
		t_sync_write();
		complete_run();
	end
endmodule
